/* File: pkg/pdw_pkg.sv */
// power-down / wake-up controller: shared constants and carriers
// assumes a single 125 MHz reference clock that never stops
package pdw_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 8;
	localparam int unsigned WDT_OSC_PERIOD_NS = 65000;
	// longest period rounds down
	localparam int unsigned WDT_OSC_CYC       = WDT_OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned WAKE_DELAY_CYC    = 1024;
	localparam int unsigned INSTR_DIV         = 4;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int unsigned PA_WIDTH      = 8;
	localparam int unsigned INT_COUNT     = 3;
	localparam int unsigned WDT_BASE_BITS = 8;
	localparam int unsigned WDT_PRE_BITS  = 7;
	localparam logic        PDF_RST       = 1'h0;
	localparam logic        TOF_RST       = 1'h0;
	localparam logic [7:0]  PA_PREV_RST   = 8'hff;

	// ------------------------------------------------------------
	// states and wake causes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PDW_RUN  = 4'h1,
		PDW_HALT = 4'h2,
		PDW_WAKE = 4'h4,
		PDW_ISR  = 4'h8
	} pdw_state_type;

	typedef enum logic [3:0] {
		PDW_CS_RST = 4'h1,
		PDW_CS_WDT = 4'h2,
		PDW_CS_PA  = 4'h4,
		PDW_CS_INT = 4'h8
	} pdw_cause_type;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic                osc_rc;
		logic                wdt_en;
		logic                wdt_src_osc;
		logic                wdt_osc_on;
		logic                clr_two;
		logic [PA_WIDTH-1:0] wake_en;
	} pdw_cfg_type;

	typedef struct packed {
		logic                 halt;
		logic                 clr_wdt;
		logic                 clr_wdt1;
		logic                 clr_wdt2;
		logic                 stack_full;
		logic [INT_COUNT-1:0] int_req;
		logic [INT_COUNT-1:0] int_en;
		logic [2:0]           wdt_sel;
	} pdw_core_type;

	typedef struct packed {
		logic sys_clk_en;
		logic core_hold;
		logic clk_src_rc;
		logic power_down_flag;
		logic watchdog_timeout_flag;
		logic rst_full;
		logic rst_pc_sp;
		logic resume_next;
		logic isr_enter;
	} pdw_stat_type;

endpackage

/* File: hdl/pdw_wdt.sv */
// watchdog_timer: 8-stage base divider plus selectable prescaler
// assumes i_tick is a one-cycle enable from the chosen wdt source
`timescale 1ns/1ps
module pdw_wdt #(
	parameter int unsigned BASE_BITS = pdw_pkg::WDT_BASE_BITS,
	parameter int unsigned PRE_BITS  = pdw_pkg::WDT_PRE_BITS
) (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_tick,
	input  wire logic       i_clear,
	input  wire logic [2:0] i_sel,
	output logic            o_overflow
);

	typedef struct packed {
		logic [PRE_BITS+BASE_BITS-1:0] cnt;
		logic                          ovf;
	} pdw_wdt_st_type;

	pdw_wdt_st_type st_ff;
	pdw_wdt_st_type nxt_st;
	logic [PRE_BITS-1:0] pre_mask;

	// ratio 1:2^sel on top of the base divider
	assign pre_mask = PRE_BITS'((1 << i_sel) - 1);

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.ovf = 1'b0;
		if (i_clear) begin
			nxt_st.cnt = '0;
		end else if (i_tick) begin
			if ((&st_ff.cnt[BASE_BITS-1:0]) &&
			    (&(st_ff.cnt[PRE_BITS+BASE_BITS-1:BASE_BITS] | ~pre_mask))) begin
				nxt_st.cnt = '0;
				nxt_st.ovf = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_overflow = st_ff.ovf;

endmodule

/* File: hdl/pdw_ctrl.sv */
// power-down and wake-up sequencer with clock source and watchdog
// assumes i_clk is the reference that keeps running in power-down;
// the system clock is modelled by o_stat.sys_clk_en
// wake pins and requests are sampled on that reference, never on the stopped clock
`timescale 1ns/1ps
module pdw_ctrl #(
	parameter int unsigned WDT_OSC_CYC = pdw_pkg::WDT_OSC_CYC,
	parameter int unsigned WAKE_CYC    = pdw_pkg::WAKE_DELAY_CYC
) (
	input  wire logic                            i_clk,
	input  wire logic                            i_arst_n,
	input  wire pdw_pkg::pdw_cfg_type            i_cfg,
	input  wire pdw_pkg::pdw_core_type           i_core,
	input  wire logic                            i_ext_rst_n,
	input  wire logic [pdw_pkg::PA_WIDTH-1:0]    i_pa,
	output logic                                 o_oscillator_output_pin_o,
	output logic                                 o_oscillator_output_pin_oe_n,
	output pdw_pkg::pdw_stat_type                o_stat
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam int unsigned DLY_W = $clog2(WAKE_CYC);
	localparam int unsigned OSC_W = $clog2(WDT_OSC_CYC + 1);

	typedef struct packed {
		pdw_pkg::pdw_state_type            state;
		pdw_pkg::pdw_cause_type            cause;
		logic                              from_halt;
		logic [DLY_W-1:0]                  dly;
		logic [1:0]                        div;
		logic [OSC_W-1:0]                  osc_cnt;
		logic [pdw_pkg::PA_WIDTH-1:0]      pa_prev;
		logic [pdw_pkg::INT_COUNT-1:0]     arm;
		logic                              clr1_pend;
		logic                              clr2_pend;
		logic                              oscillator_output_pin_o;
		logic                              oscillator_output_pin_oe_n;
		pdw_pkg::pdw_stat_type             stat;
	} pdw_ctrl_st_type;

	pdw_ctrl_st_type st_ff;
	pdw_ctrl_st_type nxt_st;

	logic                          sys_run;
	logic                          instr_tick;
	logic                          osc_tick;
	logic                          wdt_tick;
	logic                          wdt_clr;
	logic                          wdt_ovf;
	logic                          clr_ok;
	logic                          halt_take;
	logic                          pa_fall;
	logic                          int_wake;
	logic                          int_can;
	logic [pdw_pkg::PA_WIDTH-1:0]  pa_fall_pin;
	logic [pdw_pkg::INT_COUNT-1:0] int_hit;

	// ------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------
	// last phase of the instruction clock divider
	function automatic logic div_last(input logic [1:0] cnt);
		return cnt == 2'(pdw_pkg::INSTR_DIV - 1);
	endfunction

	// last reference cycle of one watchdog oscillator period
	function automatic logic osc_last(input logic [OSC_W-1:0] cnt);
		return cnt == OSC_W'(WDT_OSC_CYC - 1);
	endfunction

	// only a running core executes instructions
	function automatic logic is_run(input pdw_pkg::pdw_state_type s);
		return s == pdw_pkg::PDW_RUN;
	endfunction

	// ------------------------------------------------------------
	// clock dividers
	// ------------------------------------------------------------
	assign sys_run    = st_ff.stat.sys_clk_en;
	// instruction clock only exists while the system clock runs
	assign instr_tick = sys_run && div_last(st_ff.div);
	// watchdog oscillator is free-running, independent of power-down
	assign osc_tick   = i_cfg.wdt_osc_on && osc_last(st_ff.osc_cnt);

	// source choice decides whether power-down also freezes the count
	assign wdt_tick   = i_cfg.wdt_en &&
	                    (i_cfg.wdt_src_osc ? osc_tick : instr_tick);

	// ------------------------------------------------------------
	// core requests
	// ------------------------------------------------------------
	assign halt_take = is_run(st_ff.state) && i_core.halt;

	// two-step clear needs alternating halves; repeats of one half do nothing
	always_comb begin
		clr_ok = 1'b0;
		if (i_cfg.wdt_en && is_run(st_ff.state)) begin
			if (!i_cfg.clr_two) begin
				clr_ok = i_core.clr_wdt;
			end else begin
				clr_ok = (i_core.clr_wdt1 && st_ff.clr2_pend) ||
				         (i_core.clr_wdt2 && st_ff.clr1_pend);
			end
		end
	end

	// halt, an accepted clear and the reset pin all restart the whole count
	assign wdt_clr = halt_take ||
	                 clr_ok ||
	                 !i_ext_rst_n;

	// ------------------------------------------------------------
	// wake detection on the free-running reference
	// ------------------------------------------------------------
	// one detector per pin; a pin without its wake enable never counts
	for (genvar g = 0; g < pdw_pkg::PA_WIDTH; g++) begin : g_pa_fall
		assign pa_fall_pin[g] = st_ff.pa_prev[g] && !i_pa[g] && i_cfg.wake_en[g];
	end
	assign pa_fall  = |pa_fall_pin;

	// arm mask drops any request that was already set at entry
	for (genvar g = 0; g < pdw_pkg::INT_COUNT; g++) begin : g_int_hit
		assign int_hit[g] = i_core.int_req[g] && st_ff.arm[g];
	end
	assign int_wake = |int_hit;

	assign int_can  = (|(st_ff.arm & i_core.int_en)) &&
	                  !i_core.stack_full;

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	pdw_wdt pdw_wdt_inst (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_tick     (wdt_tick),
		.i_clear    (wdt_clr),
		.i_sel      (i_core.wdt_sel),
		.o_overflow (wdt_ovf)
	);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		nxt_st                  = st_ff;
		nxt_st.stat.rst_full    = 1'b0;
		nxt_st.stat.rst_pc_sp   = 1'b0;
		nxt_st.stat.resume_next = 1'b0;
		nxt_st.stat.isr_enter   = 1'b0;
		nxt_st.stat.clk_src_rc  = i_cfg.osc_rc;
		nxt_st.pa_prev          = i_pa;

		if (i_cfg.wdt_osc_on) begin
			if (osc_last(st_ff.osc_cnt)) begin
				nxt_st.osc_cnt = '0;
			end else begin
				nxt_st.osc_cnt = st_ff.osc_cnt + 1'b1;
			end
		end else begin
			nxt_st.osc_cnt = '0;
		end

		if (sys_run) begin
			if (div_last(st_ff.div)) begin
				nxt_st.div = '0;
			end else begin
				nxt_st.div = st_ff.div + 1'b1;
			end
		end

		if (clr_ok) begin
			nxt_st.clr1_pend = 1'b0;
			nxt_st.clr2_pend = 1'b0;
		end else if (i_cfg.clr_two && is_run(st_ff.state)) begin
			if (i_core.clr_wdt1) begin
				nxt_st.clr1_pend = 1'b1;
			end
			if (i_core.clr_wdt2) begin
				nxt_st.clr2_pend = 1'b1;
			end
		end

		case (st_ff.state)
			pdw_pkg::PDW_RUN: begin
				if (clr_ok) begin
					nxt_st.stat.power_down_flag = 1'b0;
				end
				if (!i_ext_rst_n) begin
					nxt_st.state     = pdw_pkg::PDW_WAKE;
					nxt_st.cause     = pdw_pkg::PDW_CS_RST;
					nxt_st.from_halt = 1'b0;
					nxt_st.dly       = DLY_W'(WAKE_CYC - 1);
				end else if (wdt_ovf) begin
					nxt_st.stat.watchdog_timeout_flag = 1'b1;
					nxt_st.state     = pdw_pkg::PDW_WAKE;
					nxt_st.cause     = pdw_pkg::PDW_CS_WDT;
					nxt_st.from_halt = 1'b0;
					nxt_st.dly       = DLY_W'(WAKE_CYC - 1);
				end else if (halt_take) begin
					nxt_st.state     = pdw_pkg::PDW_HALT;
					nxt_st.from_halt = 1'b1;
					nxt_st.arm       = ~i_core.int_req;
					nxt_st.stat.power_down_flag       = 1'b1;
					nxt_st.stat.watchdog_timeout_flag = 1'b0;
				end
			end

			pdw_pkg::PDW_HALT: begin
				// a watchdog on its oscillator keeps counting here; core state is simply held
				// wake priority: reset pin, watchdog, port pin, interrupt
				if (!i_ext_rst_n) begin
					nxt_st.state = pdw_pkg::PDW_WAKE;
					nxt_st.cause = pdw_pkg::PDW_CS_RST;
					nxt_st.dly   = DLY_W'(WAKE_CYC - 1);
				end else if (wdt_ovf) begin
					// power-down flag is left set as well
					nxt_st.stat.watchdog_timeout_flag = 1'b1;
					nxt_st.state = pdw_pkg::PDW_WAKE;
					nxt_st.cause = pdw_pkg::PDW_CS_WDT;
					nxt_st.dly   = DLY_W'(WAKE_CYC - 1);
				end else if (pa_fall) begin
					nxt_st.state = pdw_pkg::PDW_WAKE;
					nxt_st.cause = pdw_pkg::PDW_CS_PA;
					nxt_st.dly   = DLY_W'(WAKE_CYC - 1);
				end else if (int_wake) begin
					nxt_st.state = pdw_pkg::PDW_WAKE;
					nxt_st.cause = pdw_pkg::PDW_CS_INT;
					nxt_st.arm   = int_hit;
					nxt_st.dly   = DLY_W'(WAKE_CYC - 1);
				end
			end

			pdw_pkg::PDW_WAKE: begin
				// oscillator restarting; core stays held for the full count
				// a reset pin still low keeps reloading the count
				if (!i_ext_rst_n) begin
					nxt_st.cause = pdw_pkg::PDW_CS_RST;
					nxt_st.dly   = DLY_W'(WAKE_CYC - 1);
				end else if (st_ff.dly != '0) begin
					nxt_st.dly = st_ff.dly - 1'b1;
				end else begin
					nxt_st.state = pdw_pkg::PDW_RUN;
					case (st_ff.cause)
						pdw_pkg::PDW_CS_RST: begin
							nxt_st.stat.rst_full = 1'b1;
						end
						pdw_pkg::PDW_CS_WDT: begin
							if (st_ff.from_halt) begin
								nxt_st.stat.rst_pc_sp = 1'b1;
							end else begin
								nxt_st.stat.rst_full = 1'b1;
							end
						end
						pdw_pkg::PDW_CS_PA: begin
							nxt_st.stat.resume_next = 1'b1;
						end
						pdw_pkg::PDW_CS_INT: begin
							if (int_can) begin
								nxt_st.state = pdw_pkg::PDW_ISR;
							end else begin
								nxt_st.stat.resume_next = 1'b1;
							end
						end
						default: begin
							nxt_st.stat.rst_full = 1'b1;
						end
					endcase
					nxt_st.from_halt = 1'b0;
				end
			end

			pdw_pkg::PDW_ISR: begin
				// one extra cycle before the vector is taken
				nxt_st.state          = pdw_pkg::PDW_RUN;
				nxt_st.stat.isr_enter = 1'b1;
			end

			default: begin
				nxt_st.state = pdw_pkg::PDW_RUN;
			end
		endcase

		// derived levels follow the next state so they switch with it
		nxt_st.stat.sys_clk_en = (nxt_st.state != pdw_pkg::PDW_HALT);
		nxt_st.stat.core_hold  = !is_run(nxt_st.state);
		// open-drain pin pulls low on the low half of fsys/4 in RC mode, else released
		nxt_st.oscillator_output_pin_o    = 1'b0;
		nxt_st.oscillator_output_pin_oe_n = !i_cfg.osc_rc || nxt_st.div[1];
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff                            <= '0;
			st_ff.state                      <= pdw_pkg::PDW_RUN;
			st_ff.cause                      <= pdw_pkg::PDW_CS_RST;
			st_ff.pa_prev                    <= pdw_pkg::PA_PREV_RST;
			st_ff.oscillator_output_pin_oe_n                  <= 1'b1;
			st_ff.stat.sys_clk_en            <= 1'b1;
			st_ff.stat.power_down_flag       <= pdw_pkg::PDF_RST;
			st_ff.stat.watchdog_timeout_flag <= pdw_pkg::TOF_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_oscillator_output_pin_o    = st_ff.oscillator_output_pin_o;
	assign o_oscillator_output_pin_oe_n = st_ff.oscillator_output_pin_oe_n;
	assign o_stat      = st_ff.stat;

endmodule

/* File: tb/pdw_sva.sv */
// checker: wake timing, flag and clock-out relations at the controller ports
// port A wake timing is only checked while the watchdog is off; the bench also wakes through port A with it on
`timescale 1ns/1ps
module pdw_sva #(
	parameter int unsigned WDT_OSC_CYC = 4,
	parameter int unsigned WAKE_CYC    = 8
) (
	input wire logic                         i_clk,
	input wire logic                         i_arst_n,
	input wire pdw_pkg::pdw_cfg_type         i_cfg,
	input wire pdw_pkg::pdw_core_type        i_core,
	input wire logic                         i_ext_rst_n,
	input wire logic [pdw_pkg::PA_WIDTH-1:0] i_pa,
	input wire logic                         o_oscillator_output_pin_o,
	input wire logic                         o_oscillator_output_pin_oe_n,
	input wire pdw_pkg::pdw_stat_type        o_stat
);
	localparam int WK = WAKE_CYC;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence s_pa_fall;
		!o_stat.sys_clk_en && i_ext_rst_n && !i_cfg.wdt_en
			&& |($past(i_pa) & ~i_pa & i_cfg.wake_en);
	endsequence
	sequence s_halt_entry;
		$fell(o_stat.sys_clk_en);
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_pa_wake_delay: assert property (s_pa_fall |=> o_stat.sys_clk_en && o_stat.core_hold
		##WK !o_stat.core_hold && o_stat.resume_next) else $error("port wake timing wrong");
	a_halt_flags_set: assert property (s_halt_entry |-> o_stat.core_hold
		&& o_stat.power_down_flag && !o_stat.watchdog_timeout_flag) else $error("halt flags wrong");
	a_halt_only_cause: assert property (s_halt_entry |-> $past(i_core.halt))
		else $error("power-down without halt");
	a_osc_out_div: assert property ((o_stat.sys_clk_en && i_cfg.osc_rc)[*6]
		|-> o_oscillator_output_pin_oe_n != $past(o_oscillator_output_pin_oe_n, 2)) else $error("clock out not divided by 4");
	a_osc_out_off: assert property ((!i_cfg.osc_rc)[*2] |-> o_oscillator_output_pin_oe_n && !o_oscillator_output_pin_o)
		else $error("clock out active in crystal mode");
	a_clk_src_follow: assert property (1'b1 |=> o_stat.clk_src_rc == $past(i_cfg.osc_rc))
		else $error("clock source copy wrong");
	a_isr_after_delay: assert property (o_stat.isr_enter |-> !o_stat.core_hold
		&& $past(o_stat.core_hold) && $past(o_stat.core_hold, 2)) else $error("isr entry early");
	a_timeout_both_flags: assert property (o_stat.rst_pc_sp |-> o_stat.power_down_flag
		&& o_stat.watchdog_timeout_flag) else $error("timeout flags wrong");
	a_clr_pdf_single: assert property (i_core.clr_wdt && i_cfg.wdt_en && !i_cfg.clr_two
		&& !i_core.halt && !o_stat.core_hold |=> !o_stat.power_down_flag) else $error("pdf kept");
	a_full_rst_pulse: assert property (o_stat.rst_full |=> !o_stat.rst_full
		&& !o_stat.core_hold) else $error("full reset pulse wrong");
endmodule

bind pdw_ctrl pdw_sva #(.WDT_OSC_CYC(WDT_OSC_CYC), .WAKE_CYC(WAKE_CYC)) pdw_sva_inst (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg(i_cfg), .i_core(i_core),
	.i_ext_rst_n(i_ext_rst_n), .i_pa(i_pa), .o_oscillator_output_pin_o(o_oscillator_output_pin_o),
	.o_oscillator_output_pin_oe_n(o_oscillator_output_pin_oe_n), .o_stat(o_stat));

/* File: tb/pdw_core_model.sv */
// processor core model: turns bench opcodes into one-cycle instruction pulses
// assumes opcodes last one cycle; 1 halt, 2 clear, 3 clear half one, 4 clear half two
`timescale 1ns/1ps
module pdw_core_model (
	input  wire logic                          i_clk,
	input  wire logic                          i_arst_n,
	input  wire logic [2:0]                    i_op,
	input  wire logic [pdw_pkg::INT_COUNT-1:0] i_req,
	input  wire logic [pdw_pkg::INT_COUNT-1:0] i_en,
	input  wire logic                          i_full,
	input  wire pdw_pkg::pdw_stat_type         i_stat,
	output pdw_pkg::pdw_core_type              o_core
);
	// a held core executes nothing, so pulses issue only while it runs
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_core <= '0;
		end else begin
			o_core.halt       <= i_op == 3'h1 && !i_stat.core_hold;
			o_core.clr_wdt    <= i_op == 3'h2 && !i_stat.core_hold;
			o_core.clr_wdt1   <= i_op == 3'h3 && !i_stat.core_hold;
			o_core.clr_wdt2   <= i_op == 3'h4 && !i_stat.core_hold;
			o_core.int_req    <= i_req;
			o_core.int_en     <= i_en;
			o_core.stack_full <= i_full;
			o_core.wdt_sel    <= 3'h0;
		end
	end
endmodule

/* File: tb/pdw_ctrl_tb.sv */
// bench: power-down entry and every wake path, with flag and timing checks
// assumes the core model issues instructions; short wake and watchdog counts
`timescale 1ns/1ps
module pdw_ctrl_tb;
	localparam int WK = 8;
	localparam int WO = 4;
	logic                          clk, arst_n, ext_rst_n, full, oscillator_output_pin_o, oscillator_output_pin_oe_n;
	logic [2:0]                    op;
	logic [pdw_pkg::INT_COUNT-1:0] req, ien;
	logic [pdw_pkg::PA_WIDTH-1:0]  pa;
	pdw_pkg::pdw_cfg_type          cfg;
	pdw_pkg::pdw_core_type         core;
	pdw_pkg::pdw_stat_type         st;
	logic [3:0]                    pulses;
	int                            errors, n_compared, n;
	assign pulses = {st.rst_pc_sp, st.rst_full, st.isr_enter, st.resume_next};

	pdw_ctrl #(.WDT_OSC_CYC(WO), .WAKE_CYC(WK)) pdw_ctrl_inst (.i_clk(clk), .i_arst_n(arst_n),
		.i_cfg(cfg), .i_core(core), .i_ext_rst_n(ext_rst_n), .i_pa(pa),
		.o_oscillator_output_pin_o(oscillator_output_pin_o), .o_oscillator_output_pin_oe_n(oscillator_output_pin_oe_n), .o_stat(st));
	pdw_core_model pdw_core_model_inst (.i_clk(clk), .i_arst_n(arst_n), .i_op(op),
		.i_req(req), .i_en(ien), .i_full(full), .i_stat(st), .o_core(core));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic issue(input logic [2:0] code);
		@(posedge clk) op <= code;
		@(posedge clk) op <= 3'h0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic wait_bit(input int sel);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (pulses[sel] !== 1'b1 && n < 3000);
	endtask
	task automatic go_halt();
		issue(3'h1);
		chk("halt", {st.sys_clk_en, st.core_hold, st.power_down_flag,
			st.watchdog_timeout_flag}, 4'h6);
	endtask
	task automatic pa_wake();
		@(posedge clk) pa <= 8'hfe;
		wait_bit(0);
		chk("pa_wake", n, WK + 1);
		@(posedge clk) pa <= 8'hff;
		#1;
	endtask
	task automatic wrap_up();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// whole run is near 4300 cycles; the 25000-cycle limit, about six times that, means a hang
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	initial begin
		arst_n = 1'b0; ext_rst_n = 1'b1; pa = 8'hff; op = 3'h0;
		req = 3'h0; ien = 3'h0; full = 1'b0; errors = 0; n_compared = 0;
		cfg = '{osc_rc: 1'b0, wdt_en: 1'b0, wdt_src_osc: 1'b1, wdt_osc_on: 1'b1,
			clr_two: 1'b0, wake_en: 8'h01};
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("run", {st.sys_clk_en, st.core_hold, st.power_down_flag,
			st.watchdog_timeout_flag, oscillator_output_pin_oe_n}, 5'h11);
		@(posedge clk) cfg.osc_rc <= 1'b1;
		repeat (8) @(posedge clk);
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1;
			n += (oscillator_output_pin_oe_n === 1'b1 && oscillator_output_pin_o === 1'b0);
		end
		chk("rc_div", n, 4);
		chk("src_rc", st.clk_src_rc, 1'b1);
		@(posedge clk) cfg.osc_rc <= 1'b0;
		go_halt();
		@(posedge clk) pa <= 8'hfd;
		repeat (20) @(posedge clk);
		#1;
		chk("pin_off", st.sys_clk_en, 1'b0);
		pa_wake();
		chk("pdf_kept", {st.power_down_flag, st.core_hold}, 2'h2);
		@(posedge clk) cfg.wdt_en <= 1'b1;
		issue(3'h2);
		chk("clr", st.power_down_flag, 1'b0);
		@(posedge clk) cfg.clr_two <= 1'b1;
		go_halt();
		pa_wake();
		issue(3'h3);
		issue(3'h3);
		chk("clr_half", st.power_down_flag, 1'b1);
		issue(3'h4);
		chk("clr_two", st.power_down_flag, 1'b0);
		@(posedge clk) cfg <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h01};
		@(posedge clk) req <= 3'h1;
		ien <= 3'h1;
		go_halt();
		repeat (30) @(posedge clk);
		#1;
		chk("stale_int", st.sys_clk_en, 1'b0);
		pa_wake();
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) req <= 3'h0;
			ien <= (k == 1) ? 3'h0 : 3'h2;
			full <= (k == 2);
			go_halt();
			@(posedge clk) req <= 3'h2;
			wait_bit(k == 0 ? 1 : 0);
			chk("int_wake", n, k == 0 ? WK + 3 : WK + 2);
		end
		@(posedge clk) req <= 3'h0;
		go_halt();
		@(posedge clk) ext_rst_n <= 1'b0;
		@(posedge clk) ext_rst_n <= 1'b1;
		wait_bit(2);
		chk("ext_wake", n, WK);
		@(posedge clk) cfg.wdt_en <= 1'b1;
		go_halt();
		wait_bit(3);
		chk("wdt_time", n >= 256 * WO && n <= 256 * WO + WK + 8, 1'b1);
		chk("wdt_flags", {st.watchdog_timeout_flag, st.power_down_flag}, 2'h3);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) cfg.wdt_src_osc <= (k == 0);
			cfg.wdt_osc_on <= (k == 1);
			go_halt();
			repeat (1500) @(posedge clk);
			#1;
			chk("wdt_still", st.sys_clk_en, 1'b0);
			pa_wake();
		end
		wrap_up();
	end
endmodule
